// ---- rtl/snv_pkg.sv ----
/*
  package for the serial nonvolatile ram command engine: opcodes,
  address layout, protection ranges, identification layout, timings.
  assumes a system clock of 40 mhz and a link clock from the bus master.
*/
package snv_pkg;
  localparam logic [7:0] OP_WEN_SET_C = 8'h06;
  localparam logic [7:0] OP_WEN_CLR_C = 8'h04;
  localparam logic [7:0] OP_STAT_WR_C = 8'h01;
  localparam logic [7:0] OP_READ_C = 8'h03;
  localparam logic [7:0] OP_QUICK_C = 8'h0B;
  localparam logic [7:0] OP_WRITE_C = 8'h02;
  localparam logic [7:0] OP_SLEEP_C = 8'hB9;
  localparam logic [7:0] OP_IDENT_C = 8'h9F;
  localparam int ADDR_W = 15;
  localparam logic [14:0] ADDR_TOP_C = 15'h7FFF;
  localparam logic [14:0] PROT_QTR_C = 15'h6000;
  localparam logic [14:0] PROT_HALF_C = 15'h4000;
  localparam int ID_BYTES = 9;
  // arbitrary neutral identity values
  localparam logic [55:0] ID_MAKER_C = 56'h11_11_11_11_11_11_22;
  localparam logic [2:0] ID_FAMILY_C = 3'h1;
  localparam logic [4:0] ID_DENSITY_C = 5'h02;
  localparam logic [1:0] ID_SUB_C = 2'h0;
  localparam logic [2:0] ID_REV_C = 3'h0;
  localparam int WAKE_NS = 450000;
  localparam int CLK_NS = 25;
  localparam int WAKE_CYC = WAKE_NS / CLK_NS;

  typedef enum logic [6:0] {
    SNV_OPC = 7'h01, SNV_ADH = 7'h02, SNV_ADL = 7'h04, SNV_DUM = 7'h08,
    SNV_WR = 7'h10, SNV_RD = 7'h20, SNV_IGN = 7'h40
  } snv_state_t;

  typedef struct packed {
    logic        valid;
    logic [14:0] addr;
    logic [7:0]  data;
  } snv_wreq_t;
endpackage

// ---- rtl/snv_engine.sv ----
/*
  serial nonvolatile ram command engine: link logic on the serial clock,
  array write port and sleep/wake state on clk_sys.
  assumes the bus master drives select, clock, data in and hold; the
  serial clock may stop between frames.
*/
module snv_engine
  import snv_pkg::*;
#(
  parameter int WAKE_CYCLES = WAKE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic sck,
  input wire logic cs_b,
  input wire logic si,
  input wire logic hold_b,
  input wire logic block_protect_low,
  input wire logic block_protect_high,
  output logic so_o,
  output logic so_oe,
  output logic write_enable_flag,
  output logic asleep,
  output logic waking
);
  logic [7:0] mem [0:(1 << ADDR_W) - 1];
  snv_state_t st_q;
  logic [2:0] bit_q;
  logic [6:0] sh_q;
  logic [7:0] op_q;
  logic [14:0] addr_q;
  logic [7:0] tx_q;
  logic [3:0] id_q;
  logic stop_q;
  logic wel_q;
  logic frm_q;
  logic [7:0] byte_w;
  logic [7:0] out_byte;
  logic so_l_q;
  logic oe_l_q;
  logic [7:0] rd_byte;
  snv_wreq_t wreq_q;
  logic wr_tgl_q;
  logic sleep_tgl_q;
  logic wake_tgl_q;

  ////////////////////////////////////////////////////////////////////////
  function automatic logic prot_hit(input logic [1:0] bp, input logic [14:0] a);
    case (bp)
      2'b01: prot_hit = a >= PROT_QTR_C;
      2'b10: prot_hit = a >= PROT_HALF_C;
      2'b11: prot_hit = 1'b1;
      default: prot_hit = 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] id_byte(input logic [3:0] i);
    logic [71:0] id;
    id = {ID_MAKER_C, ID_FAMILY_C, ID_DENSITY_C, ID_SUB_C, ID_REV_C, 3'h0};
    if (i < 4'd9) begin
      id_byte = id[71 - 8 * i -: 8];
    end else begin
      id_byte = 8'h00;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // sleep state seen from the link side (slow level, resynced)
  logic sl_m_q, sl_l_q, wk_m_q, wk_l_q;
  always_ff @(posedge sck or posedge cs_b) begin
    if (cs_b) begin
      sl_m_q <= 1'b0;
      sl_l_q <= 1'b0;
      wk_m_q <= 1'b0;
      wk_l_q <= 1'b0;
    end else begin
      sl_m_q <= asleep | waking;
      sl_l_q <= sl_m_q;
      wk_m_q <= 1'b0;
      wk_l_q <= wk_m_q;
    end
  end

  assign byte_w = {sh_q, si};
  assign rd_byte = mem[addr_q];

  ////////////////////////////////////////////////////////////////////////
  // command decoding on rising serial clock; select high resets the frame
  always_ff @(posedge sck or posedge cs_b) begin
    if (cs_b) begin
      st_q <= SNV_OPC;
      bit_q <= 3'd0;
      sh_q <= 7'h00;
      stop_q <= 1'b0;
      frm_q <= 1'b0;
    end else if (hold_b) begin
      bit_q <= bit_q + 3'd1;
      sh_q <= byte_w[6:0];
      frm_q <= 1'b1;
      if (bit_q == 3'd7) begin
        case (st_q)
          SNV_OPC: begin
            if (sl_l_q) begin
              st_q <= SNV_IGN;
            end else if (byte_w == OP_WRITE_C || byte_w == OP_READ_C ||
                byte_w == OP_QUICK_C) begin
              st_q <= SNV_ADH;
            end else if (byte_w == OP_IDENT_C) begin
              st_q <= SNV_RD;
            end else begin
              st_q <= SNV_IGN;
            end
          end
          SNV_ADH: st_q <= SNV_ADL;
          SNV_ADL: begin
            if (op_q == OP_WRITE_C) begin
              st_q <= SNV_WR;
            end else if (op_q == OP_QUICK_C) begin
              st_q <= SNV_DUM;
            end else begin
              st_q <= SNV_RD;
            end
          end
          SNV_DUM: st_q <= SNV_RD;
          SNV_WR: begin
            if (!wel_q || prot_hit({block_protect_high, block_protect_low}, addr_q)) begin
              stop_q <= 1'b1;
            end
          end
          default: st_q <= st_q;
        endcase
      end
    end
  end

  // opcode latch and address counter
  always_ff @(posedge sck or negedge rst_b) begin
    if (!rst_b) begin
      op_q <= 8'h00;
      addr_q <= 15'h0000;
      id_q <= 4'd0;
    end else if (!cs_b && hold_b && bit_q == 3'd7) begin
      if (st_q == SNV_OPC) begin
        op_q <= byte_w;
        id_q <= 4'd0;
      end else if (st_q == SNV_ADH) begin
        addr_q <= {byte_w[6:0], 8'h00};
      end else if (st_q == SNV_ADL) begin
        addr_q <= {addr_q[14:8], byte_w};
      end else if (st_q == SNV_WR) begin
        if (!stop_q && wel_q &&
            !prot_hit({block_protect_high, block_protect_low}, addr_q)) begin
          addr_q <= addr_q + 15'd1;
        end
      end else if (st_q == SNV_RD) begin
        if (op_q == OP_IDENT_C) begin
          id_q <= id_q + 4'd1;
        end else begin
          addr_q <= addr_q + 15'd1;
        end
      end
    end
  end

  // write flag: set by write enable, cleared by write disable, status write or write, all at select rise
  always_ff @(posedge cs_b or negedge rst_b) begin
    if (!rst_b) begin
      wel_q <= 1'b0;
    end else if (frm_q) begin
      if (op_q == OP_WEN_SET_C && st_q == SNV_IGN) begin
        wel_q <= 1'b1;
      end else if ((op_q == OP_WEN_CLR_C && st_q == SNV_IGN) || op_q == OP_STAT_WR_C ||
          (op_q == OP_WRITE_C && st_q != SNV_OPC)) begin
        wel_q <= 1'b0;
      end
    end
  end

  // sleep request toggles on select rise after full sleep code
  always_ff @(posedge cs_b or negedge rst_b) begin
    if (!rst_b) begin
      sleep_tgl_q <= 1'b0;
    end else if (frm_q && op_q == OP_SLEEP_C && st_q == SNV_IGN && !sl_l_q) begin
      sleep_tgl_q <= ~sleep_tgl_q;
    end
  end

  // wake event toggles on select fall
  always_ff @(negedge cs_b or negedge rst_b) begin
    if (!rst_b) begin
      wake_tgl_q <= 1'b0;
    end else begin
      wake_tgl_q <= ~wake_tgl_q;
    end
  end

  // array write request: only completed bytes toggle a request
  always_ff @(posedge sck or negedge rst_b) begin
    if (!rst_b) begin
      wreq_q <= '0;
      wr_tgl_q <= 1'b0;
    end else if (!cs_b && hold_b && bit_q == 3'd7 && st_q == SNV_WR && !stop_q &&
        wel_q && !prot_hit({block_protect_high, block_protect_low}, addr_q)) begin
      wreq_q <= '{valid: 1'b1, addr: addr_q, data: byte_w};
      wr_tgl_q <= ~wr_tgl_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output shifter on falling clock
  assign out_byte = (op_q == OP_IDENT_C) ? id_byte(id_q) : rd_byte;
  always_ff @(negedge sck or posedge cs_b) begin
    if (cs_b) begin
      tx_q <= 8'h00;
      so_l_q <= 1'b0;
      oe_l_q <= 1'b0;
    end else if (hold_b) begin
      if (st_q == SNV_RD) begin
        if (bit_q == 3'd0) begin
          so_l_q <= out_byte[7];
          tx_q <= {out_byte[6:0], 1'b0};
        end else begin
          so_l_q <= tx_q[7];
          tx_q <= {tx_q[6:0], 1'b0};
        end
        oe_l_q <= 1'b1;
      end else begin
        oe_l_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // system side synchronisers
  logic [2:0] wr_s_q, sl_s_q, wk_s_q;
  logic [1:0] oe_s_q, so_s_q;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wr_s_q <= 3'b000;
      sl_s_q <= 3'b000;
      wk_s_q <= 3'b000;
      oe_s_q <= 2'b00;
      so_s_q <= 2'b00;
    end else begin
      wr_s_q <= {wr_s_q[1:0], wr_tgl_q};
      sl_s_q <= {sl_s_q[1:0], sleep_tgl_q};
      wk_s_q <= {wk_s_q[1:0], wake_tgl_q};
      oe_s_q <= {oe_s_q[0], oe_l_q & hold_b};
      so_s_q <= {so_s_q[0], so_l_q};
    end
  end

  // array commit once the request toggle crosses
  always_ff @(posedge clk_sys) begin
    if (wr_s_q[2] != wr_s_q[1] && wreq_q.valid) begin
      mem[wreq_q.addr] <= wreq_q.data;
    end
  end

  // sleep and wake sequencing
  logic [$clog2(WAKE_CYCLES + 1) - 1:0] wake_cnt_q;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      asleep <= 1'b0;
      waking <= 1'b0;
      wake_cnt_q <= '0;
    end else if (sl_s_q[2] != sl_s_q[1]) begin
      asleep <= 1'b1;
      waking <= 1'b0;
    end else if (asleep && wk_s_q[2] != wk_s_q[1]) begin
      asleep <= 1'b0;
      waking <= 1'b1;
      wake_cnt_q <= '0;
    end else if (waking) begin
      if (wake_cnt_q == ($clog2(WAKE_CYCLES + 1))'(WAKE_CYCLES - 1)) begin
        waking <= 1'b0;
      end
      wake_cnt_q <= wake_cnt_q + ($clog2(WAKE_CYCLES + 1))'(1);
    end
  end

  // pin outputs from flops; output floats while asleep or waking
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      so_o <= 1'b0;
      so_oe <= 1'b0;
      write_enable_flag <= 1'b0;
    end else begin
      so_o <= so_s_q[1];
      so_oe <= oe_s_q[1] & ~asleep & ~waking & ~cs_b;
      write_enable_flag <= wel_q;
    end
  end
endmodule

// ---- testbench/snv_host.sv ----
/*
  bus master model for the serial ram engine.
  assumes mode 0 framing; the serial clock stands still low between frames.
*/
module snv_host (
  output logic sck,
  output logic cs_b,
  output logic si,
  output logic hold_b,
  input wire logic so_o,
  input wire logic so_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 103;
  // idle bus
  initial begin
    sck = 1'b0;
    cs_b = 1'b1;
    si = 1'b0;
    hold_b = 1'b1;
  end
  // select edge, then a quiet half period
  task automatic sel(input logic on);
    #HALF cs_b = !on;
    si = !si;
    #HALF;
  endtask
  // shift n bits msb first; so is taken on each rising edge
  task automatic xfer(input int n, input logic [7:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      si = tx[i];
      #HALF sck = 1'b1;
      rx[i] = so_oe ? so_o : 1'bx;
      #HALF sck = 1'b0;
    end
  endtask
  // hold mid frame while clock and data wiggle
  task automatic pause();
    hold_b = 1'b0;
    repeat (3) begin
      si = !si;
      #HALF sck = 1'b1;
      #HALF sck = 1'b0;
    end
    hold_b = 1'b1;
  endtask
endmodule

// ---- testbench/snv_engine_chk.sv ----
/*
  checker for the serial ram engine ports.
  assumes one clk_sys domain with rst_b as its reset.
*/
module snv_engine_chk
  import snv_pkg::*;
#(
  parameter int WAKE_CYCLES = WAKE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic sck,
  input wire logic cs_b,
  input wire logic si,
  input wire logic hold_b,
  input wire logic block_protect_low,
  input wire logic block_protect_high,
  input wire logic so_o,
  input wire logic so_oe,
  input wire logic write_enable_flag,
  input wire logic asleep,
  input wire logic waking
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  logic [31:0] wake_cnt_q;
  // cycles spent waking
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wake_cnt_q <= '0;
    end else begin
      wake_cnt_q <= waking ? wake_cnt_q + 32'h1 : '0;
    end
  end
  ////////////////////////////////////////////////////////////////
  sequence s_sel_rise; $rose(cs_b); endsequence
  sequence s_quiet; !so_oe; endsequence
  property p_oe_release; s_sel_rise |-> ##[0:3] s_quiet; endproperty
  property p_oe_select;
    so_oe |-> !cs_b || !$past(cs_b) || !$past(cs_b, 2) || !$past(cs_b, 3);
  endproperty
  property p_sleep_quiet; asleep |-> s_quiet; endproperty
  property p_wake_quiet; waking |-> s_quiet; endproperty
  property p_sleep_entry; $rose(asleep) |-> cs_b; endproperty
  property p_wake_start; asleep && $fell(cs_b) |-> ##[1:4] waking; endproperty
  property p_wake_bound; wake_cnt_q <= WAKE_CYCLES + 4; endproperty
  property p_flag_clear; $fell(write_enable_flag) |-> cs_b; endproperty
  a_oe_release: assert property (p_oe_release) else $error("output still driven");
  a_oe_select: assert property (p_oe_select) else $error("driven while idle");
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("driven asleep");
  a_wake_quiet: assert property (p_wake_quiet) else $error("driven waking");
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep mid frame");
  a_wake_start: assert property (p_wake_start) else $error("no wake start");
  a_wake_bound: assert property (p_wake_bound) else $error("wake too long");
  a_flag_clear: assert property (p_flag_clear) else $error("flag cleared early");
endmodule
bind snv_engine snv_engine_chk #(.WAKE_CYCLES(WAKE_CYCLES)) u_chk (
  .clk_sys(clk_sys), .rst_b(rst_b), .sck(sck), .cs_b(cs_b), .si(si), .hold_b(hold_b),
  .block_protect_low(block_protect_low), .block_protect_high(block_protect_high),
  .so_o(so_o), .so_oe(so_oe), .write_enable_flag(write_enable_flag),
  .asleep(asleep), .waking(waking)
);

// ---- testbench/snv_engine_test.sv ----
/*
  testbench for the serial ram engine: frames from the host model.
  assumes a short wake count and the host model beside the engine.
*/
module snv_engine_test;
  import snv_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int WK = 20;
  logic clk_sys = 1'b0, rst_b = 1'b0, sck, cs_b, si, hold_b, so_o, so_oe;
  logic write_enable_flag, asleep, waking;
  logic [1:0] bp = 2'h0;
  logic [71:0] rd;
  logic [23:0] exp;
  logic [14:0] base [2] = '{15'h3FFF, 15'h5FFF};
  bit blk;
  int num_errors = 0, samples_checked = 0;
  always #12.5 clk_sys = !clk_sys;
  snv_engine #(.WAKE_CYCLES(WK)) u_snv_engine (.clk_sys(clk_sys), .rst_b(rst_b), .sck(sck),
    .cs_b(cs_b), .si(si), .hold_b(hold_b), .block_protect_low(bp[0]),
    .block_protect_high(bp[1]), .so_o(so_o), .so_oe(so_oe),
    .write_enable_flag(write_enable_flag), .asleep(asleep), .waking(waking));
  snv_host u_host (.sck(sck), .cs_b(cs_b), .si(si), .hold_b(hold_b), .so_o(so_o),
    .so_oe(so_oe));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [71:0] seen, input logic [71:0] want);
    samples_checked++;
    if (seen !== want) begin
      num_errors++;
      $display("[ERR] %0t mismatch %h expected %h", $time, seen, want);
    end
  endtask
  task automatic close_out();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // one frame: bytes out, optional partial byte and hold, then reads
  task automatic go(input logic [7:0] b[$], input int nrd, input int part, input bit hld,
    output logic [71:0] r);
    logic [7:0] x;
    r = '0;
    u_host.sel(1'b1);
    foreach (b[i]) u_host.xfer(8, b[i], x);
    if (part > 0) u_host.xfer(part, 8'hFF, x);
    if (hld) u_host.pause();
    repeat (nrd) begin
      u_host.xfer(8, 8'hA5, x);
      r = {r[63:0], x};
    end
    u_host.sel(1'b0);
  endtask
  // enable, then a three byte burst
  task automatic wr(input logic [14:0] a, input logic [7:0] v);
    go('{OP_WEN_SET_C}, 0, 0, 0, rd);
    go('{OP_WRITE_C, {1'b0, a[14:8]}, a[7:0], v, v + 8'h01, v + 8'h02}, 0, 0, 0, rd);
  endtask
  function automatic bit prot(input logic [14:0] a, input int k);
    return (k == 3) || (k == 2 && a >= 15'h4000) || (k == 1 && a >= 15'h6000);
  endfunction
  ////////////////////////////////////////////////////////////////
  initial begin
    #2ms;
    num_errors++;
    close_out();
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk(write_enable_flag, 1'h0);
    go('{OP_WEN_SET_C}, 0, 0, 0, rd);
    chk(write_enable_flag, 1'h1);
    go('{OP_WEN_CLR_C}, 0, 0, 0, rd);
    chk(write_enable_flag, 1'h0);
    // burst across the top, read back with top address bit set
    wr(15'h7FFF, 8'h11);
    chk(write_enable_flag, 1'h0);
    go('{OP_QUICK_C, 8'hFF, 8'hFF, 8'h00}, 3, 0, 0, rd);
    chk(rd[23:0], 24'h111213);
    // write without the flag, read with a hold in mid frame
    go('{OP_WRITE_C, 8'h00, 8'h00, 8'h99}, 0, 0, 0, rd);
    go('{OP_READ_C, 8'h80, 8'h00}, 1, 0, 1, rd);
    chk(rd[7:0], 8'h12);
    // partial byte at select rise
    wr(15'h0100, 8'h21);
    go('{OP_WEN_SET_C}, 0, 0, 0, rd);
    go('{OP_WRITE_C, 8'h01, 8'h00, 8'hC3}, 0, 4, 0, rd);
    go('{OP_READ_C, 8'h01, 8'h00}, 2, 0, 0, rd);
    chk(rd[15:0], 16'hC322);
    // every protect code at both boundaries
    for (int k = 0; k < 4; k++) begin
      foreach (base[j]) begin
        @(posedge clk_sys) bp <= 2'h0;
        wr(base[j], 8'h10);
        @(posedge clk_sys) bp <= 2'(k);
        wr(base[j], 8'hE0);
        go('{OP_READ_C, {1'b0, base[j][14:8]}, base[j][7:0]}, 3, 0, 0, rd);
        blk = 1'b0;
        for (int n = 0; n < 3; n++) begin
          blk |= prot(base[j] + 15'(n), k);
          exp = {exp[15:0], blk ? 8'h10 + 8'(n) : 8'hE0 + 8'(n)};
        end
        chk(rd[23:0], exp);
      end
    end
    // sleep, wake on a throwaway frame, then work again
    go('{OP_SLEEP_C}, 0, 0, 0, rd);
    repeat (4) @(negedge clk_sys);
    chk(asleep, 1'h1);
    u_host.sel(1'b1);
    repeat (4) @(negedge clk_sys);
    chk({waking, so_oe}, 2'h2);
    u_host.sel(1'b0);
    repeat (WK + 8) @(posedge clk_sys);
    chk({asleep, waking}, 2'h0);
    go('{OP_READ_C, 8'h7F, 8'hFF}, 1, 0, 0, rd);
    chk(rd[7:0], 8'h11);
    go('{OP_IDENT_C}, 9, 0, 0, rd);
    chk(rd, {ID_MAKER_C, ID_FAMILY_C, ID_DENSITY_C, ID_SUB_C, ID_REV_C, 3'h0});
    close_out();
  end
endmodule
